// ### verilog/cfg_protect_params.svh
// Functional notes
// - One-way option set: lock bit sets once after unlock, then pin writes refused.
// - One-way option clear: lock bit set or cleared freely after each unlock.
// - USB regulator disabled when its config bit is one, enabled when zero.
// - Oscillator field: 11 off, 10 fast crystal, 01 crystal, 00 external clock.
// - Word three unimplemented bits 23..16 and 12..8 read back as one.
// - End-page select one: protect from address zero to end of boundary page.
// - End-page select zero: protect from boundary page start to last page.
// - Last-page select zero protects top page and config words; one leaves them.
// - Segment disable one turns segment protection off; zero enables the defined segment.
// - Boundary field names a 512-word page counted up from page zero.
// - With core regulator on, hold execution about 10 us after power-up.
// - Regulator hold-off applies on power-up with regulator on, and on Sleep wake only while the standby bit is clear.
// - Hold-off length depends on the sleep regulator standby control bit.
// - Regulator off: power-up timer adds 64 ms after power-on or brown-out only.
// - Regulator off: standby bit set gives the shorter Sleep wake-up.
// - Standby bit set keeps regulator on in Sleep, wake skips the hold-off.
`ifndef CFG_PROTECT_PARAMS_SVH
`define CFG_PROTECT_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_WORD_TWO    4'h0
`define ADDR_WORD_THREE  4'h1
`define ADDR_PIN_CTRL    4'h2
`define ADDR_STATUS      4'h3
`define ADDR_STANDBY     4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define W2_ONE_WAY_BIT   4
`define W2_USB_DIS_BIT   3
`define W2_RSVD_BIT      2
`define W2_OSC_HI        1
`define W2_OSC_LO        0
`define W3_END_PAGE_BIT  15
`define W3_LAST_PAGE_BIT 14
`define W3_SEG_DIS_BIT   13
`define W3_PAGE_HI       7
`define W3_PAGE_LO       0
`define W3_ONES_MASK     24'hFF1F00
`define PAGE_SHIFT       9
`define PC_UNLOCK_BIT    0
`define PC_LOCK_BIT      1
`define PC_KEY_BIT       2

// ----------------------------------------------------------------
// Unlock key values and defaults
// ----------------------------------------------------------------
`define UNLOCK_KEY_A     8'h46
`define UNLOCK_KEY_B     8'h57
`define CFG_ERASED       24'hFFFFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ          200
`define REGULATOR_STARTUP_HOLDOFF_US         10
`define REGULATOR_STARTUP_HOLDOFF_CYC        (`REGULATOR_STARTUP_HOLDOFF_US * `CLK_MHZ)
`define POWER_UP_DELAY_TIMER_MS          64
`define POWER_UP_DELAY_TIMER_CYC         (`POWER_UP_DELAY_TIMER_MS * 1000 * `CLK_MHZ)
`define WAKE_FAST_CYC    1

`endif

// ### verilog/cfg_protect_pkg.sv
package cfg_protect_pkg;

  typedef enum logic [1:0]
  {
    osc_external_clock_input,
    osc_standard_crystal,
    osc_high_speed_crystal,
    osc_disabled
  } osc_mode_t;

  typedef struct packed
  {
    logic        pin_lock_one_way;
    logic        usb_regulator_disable;
    osc_mode_t   primary_osc_select;
    logic        protect_end_page_select;
    logic        last_page_protect_select;
    logic        segment_protect_disable;
    logic [7:0]  protect_boundary_page;
  } cfg_fields_t;

  typedef struct packed
  {
    logic        valid;
    logic        erase;
    logic [23:0] addr;
  } nvm_req_t;

  typedef enum
  {
    st_reset,
    st_holdoff,
    st_run,
    st_sleep
  } pwr_state_t;

endpackage

// ### verilog/region_check.sv
`timescale 1ns/1ps
`include "cfg_protect_params.svh"
// Decides whether a program address sits in a protected region.
module region_check #(
  parameter int LAST_PAGE = 8'h7F
) (
  // Decoded configuration.
  input  wire cfg_protect_pkg::cfg_fields_t cfg,
  // Address to test.
  input  wire logic [23:0]                 addr,
  input  wire logic                        is_cfg_area,
  // Verdict.
  output logic                             hit
);
  import cfg_protect_pkg::*;

  logic [14:0] page;
  logic [14:0] bound;
  logic        seg_hit;
  logic        top_hit;

  // Page index of the word address and of the boundary page.
  assign page  = addr[23:`PAGE_SHIFT];
  assign bound = {7'h00, cfg.protect_boundary_page};

  // Segment test below or above the boundary page, each inclusive.
  assign seg_hit = !cfg.segment_protect_disable &&
                   (cfg.protect_end_page_select ? (page <= bound)
                                                : (page >= bound));

  // Top page and configuration area follow the last-page select.
  assign top_hit = !cfg.last_page_protect_select &&
                   (is_cfg_area || page == 15'(LAST_PAGE));

  assign hit = seg_hit || top_hit;
endmodule

// ### verilog/startup_timer.sv
`timescale 1ns/1ps
`include "cfg_protect_params.svh"
// Down-counter that holds execution off for a loaded number of cycles.
module startup_timer #(
  parameter int CW = 24
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          nrst,
  // Load and status.
  input  wire logic          load,
  input  wire logic [CW-1:0] count,
  output logic               busy
);
  logic [CW-1:0] cnt_r;

  // Count down to zero; a load restarts the wait.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= '0;
    else if (load)
      cnt_r <= count;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign busy = (cnt_r != '0);
endmodule

// ### verilog/cfg_protect.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "cfg_protect_params.svh"
// Configuration word decode, code protection and start-up hold-off.
module cfg_protect #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = `POWER_UP_DELAY_TIMER_CYC,
  parameter int LAST_PAGE   = 8'h7F
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Stored configuration words from nonvolatile memory.
  input  wire logic [23:0]                 nv_word_two,
  input  wire logic [23:0]                 nv_word_three,
  // Power events and regulator strap.
  input  wire logic                        core_reg_enable,
  input  wire logic                        por_event,
  input  wire logic                        brownout_reset,
  input  wire logic                        sleep_enter,
  input  wire logic                        wake_event,
  // Program memory requests.
  input  wire cfg_protect_pkg::nvm_req_t   nvm_req,
  input  wire logic                        nvm_req_cfg,
  // Register port.
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [23:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [23:0]                      reg_rdata,
  // Effects.
  output logic                             usb_reg_en,
  output cfg_protect_pkg::osc_mode_t       osc_mode,
  output logic                             run_enable,
  output logic                             flash_powered,
  output logic                             pin_select_lock,
  output logic                             pin_write_ok,
  output logic                             nvm_grant,
  output logic                             nvm_block
);
  import cfg_protect_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [1:0] fill_r;

  // Two stages before use; a third stage feeds edge detection.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      fill_r <= '0;
    end
    else
    begin
      s1_r <= {core_reg_enable, por_event, brownout_reset,
               sleep_enter, wake_event};
      s2_r <= s1_r;
      s3_r <= s2_r;
      fill_r <= {fill_r[0], 1'b1};  // Marks both stages as filled.
    end
  end

  wire reg_on   = s2_r[4];
  wire pwr_rise = (s2_r[3] & ~s3_r[3]) | (s2_r[2] & ~s3_r[2]);
  wire slp_rise = s2_r[1] & ~s3_r[1];
  wire wak_rise = s2_r[0] & ~s3_r[0];

  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  logic [23:0] w2_r;
  logic [23:0] w3_r;
  logic        cap_done_r;

  // Words are taken once, on the first edge after reset release.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w2_r       <= `CFG_ERASED;
      w3_r       <= `CFG_ERASED;
      cap_done_r <= 1'b0;
    end
    else if (!cap_done_r)
    begin
      w2_r       <= nv_word_two;
      w3_r       <= nv_word_three;
      cap_done_r <= 1'b1;
    end
  end

  cfg_fields_t cfg;
  assign cfg.pin_lock_one_way         = w2_r[`W2_ONE_WAY_BIT];
  assign cfg.usb_regulator_disable    = w2_r[`W2_USB_DIS_BIT];
  assign cfg.primary_osc_select       =
    osc_mode_t'(w2_r[`W2_OSC_HI:`W2_OSC_LO]);
  assign cfg.protect_end_page_select  = w3_r[`W3_END_PAGE_BIT];
  assign cfg.last_page_protect_select = w3_r[`W3_LAST_PAGE_BIT];
  assign cfg.segment_protect_disable  = w3_r[`W3_SEG_DIS_BIT];
  assign cfg.protect_boundary_page    = w3_r[`W3_PAGE_HI:`W3_PAGE_LO];

  // Reserved bit two is expected as one; it is only reported back.
  wire rsvd_ok = w2_r[`W2_RSVD_BIT];

  // ----------------------------------------------------------------
  // Pin-select lock with unlock sequence
  // ----------------------------------------------------------------
  logic [1:0] key_st_r;
  logic       unlocked_r;
  logic       lock_r;
  logic       lock_used_r;

  wire wr_pin  = reg_wr && reg_addr == `ADDR_PIN_CTRL;
  wire key_a   = wr_pin && reg_wdata[`PC_KEY_BIT]
                 && reg_wdata[23:16] == `UNLOCK_KEY_A;
  wire key_b   = wr_pin && reg_wdata[`PC_KEY_BIT]
                 && reg_wdata[23:16] == `UNLOCK_KEY_B;
  wire lock_wr = wr_pin && !reg_wdata[`PC_KEY_BIT] && unlocked_r;
  wire want    = reg_wdata[`PC_LOCK_BIT];
  wire chg_ok  = cfg.pin_lock_one_way
                 ? (!lock_used_r && want)
                 : 1'b1;

  // Two key writes back to back open one lock change.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      key_st_r <= 2'h0;
    else if (key_a)
      key_st_r <= 2'h1;
    else if (key_b && key_st_r == 2'h1)
      key_st_r <= 2'h2;
    else if (reg_wr)
      key_st_r <= 2'h0;
  end

  // The unlock stays open until the next register write uses it up.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      unlocked_r <= 1'b0;
    else if (key_b && key_st_r == 2'h1)
      unlocked_r <= 1'b1;
    else if (reg_wr)
      unlocked_r <= 1'b0;
  end

  // Lock changes only right after a completed unlock.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_r      <= 1'b0;
      lock_used_r <= 1'b0;
    end
    else if (lock_wr && chg_ok)
    begin
      lock_r      <= want;
      lock_used_r <= lock_used_r | want;
    end
  end

  // ----------------------------------------------------------------
  // Power sequencing
  // ----------------------------------------------------------------
  pwr_state_t st_r;
  pwr_state_t st_nxt;
  logic       standby_r;
  logic       tmr_load;
  logic [31:0] tmr_count;
  logic       tmr_busy;

  wire long_wait = !standby_r;

  // Select the hold-off on each entry to the waiting state.
  always_comb
  begin
    st_nxt    = st_r;
    tmr_load  = 1'b0;
    tmr_count = 32'(`WAKE_FAST_CYC);
    case (st_r)
      st_reset:
        // Leave only once the strap has crossed both stages.
        if (fill_r[1])
        begin
          st_nxt    = st_holdoff;
          tmr_load  = 1'b1;
          tmr_count = reg_on ? 32'(`REGULATOR_STARTUP_HOLDOFF_CYC)
                             : 32'(POWER_UP_DELAY_TIMER_CYCLES);
        end
      st_holdoff:
        if (!tmr_busy)
          st_nxt = st_run;
      st_run:
        if (pwr_rise)
          st_nxt = st_reset;
        else if (slp_rise)
          st_nxt = st_sleep;
      st_sleep:
        if (pwr_rise)
          st_nxt = st_reset;
        else if (wak_rise)
        begin
          st_nxt   = st_holdoff;
          tmr_load = 1'b1;
          tmr_count = long_wait
                      ? 32'(`REGULATOR_STARTUP_HOLDOFF_CYC)
                      : 32'(`WAKE_FAST_CYC);
        end
      default:
        st_nxt = st_reset;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= st_reset;
    else
      st_r <= st_nxt;
  end

  startup_timer #(
    .CW (32)
  ) u_timer (
    .clk   (clk),
    .nrst  (nrst),
    .load  (tmr_load),
    .count (tmr_count),
    .busy  (tmr_busy)
  );

  wire wr_stby = reg_wr && reg_addr == `ADDR_STANDBY;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      standby_r <= 1'b0;
    else if (wr_stby)
      standby_r <= reg_wdata[0];
  end

  // ----------------------------------------------------------------
  // Program memory protection
  // ----------------------------------------------------------------
  logic prot_hit;

  region_check #(
    .LAST_PAGE (LAST_PAGE)
  ) u_region (
    .cfg         (cfg),
    .addr        (nvm_req.addr),
    .is_cfg_area (nvm_req_cfg),
    .hit         (prot_hit)
  );

  // ----------------------------------------------------------------
  // Register read and outputs
  // ----------------------------------------------------------------
  logic [23:0] rd_mux;
  wire  [23:0] status = {18'h0, tmr_busy, lock_used_r, rsvd_ok,
                         (st_r == st_sleep), (st_r == st_run), lock_r};

  assign rd_mux =
    (reg_addr == `ADDR_WORD_TWO)   ? w2_r :
    (reg_addr == `ADDR_WORD_THREE) ? (w3_r | `W3_ONES_MASK) :
    (reg_addr == `ADDR_PIN_CTRL)   ? {22'h0, lock_r, 1'b0} :
    (reg_addr == `ADDR_STATUS)     ? status :
    (reg_addr == `ADDR_STANDBY)    ? {23'h0, standby_r} : 24'h000000;

  // All outputs registered.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata       <= 24'h000000;
      usb_reg_en      <= 1'b0;
      osc_mode        <= osc_disabled;
      run_enable      <= 1'b0;
      flash_powered   <= 1'b1;
      pin_select_lock <= 1'b0;
      pin_write_ok    <= 1'b0;
      nvm_grant       <= 1'b0;
      nvm_block       <= 1'b0;
    end
    else
    begin
      reg_rdata       <= reg_rd ? rd_mux : 24'h000000;
      usb_reg_en      <= cap_done_r && !cfg.usb_regulator_disable;
      osc_mode        <= cfg.primary_osc_select;
      run_enable      <= (st_nxt == st_run);
      flash_powered   <= (st_nxt != st_sleep) || standby_r;
      pin_select_lock <= lock_r;
      pin_write_ok    <= !lock_r;
      nvm_grant       <= nvm_req.valid && !prot_hit;
      nvm_block       <= nvm_req.valid && prot_hit;
    end
  end
endmodule

// ### dv/cfg_protect_chk.sv
`timescale 1ns/1ps
`include "cfg_protect_params.svh"
// ----------------------------------------------------------------
// Port-level properties of the configuration protection block
// ----------------------------------------------------------------
module cfg_protect_chk (
  // Clock and reset.
  input wire logic                       clk,
  input wire logic                       nrst,
  // Configuration and power inputs.
  input wire logic [23:0]                nv_word_two,
  input wire logic                       por_event,
  // Register port.
  input wire logic [3:0]                 reg_addr,
  input wire logic                       reg_rd,
  input wire logic [23:0]                reg_rdata,
  // Program memory requests and answers.
  input wire cfg_protect_pkg::nvm_req_t  nvm_req,
  input wire logic                       nvm_grant,
  input wire logic                       nvm_block,
  // Effects.
  input wire cfg_protect_pkg::osc_mode_t osc_mode,
  input wire logic                       usb_reg_en,
  input wire logic                       run_enable,
  input wire logic                       flash_powered,
  input wire logic                       pin_select_lock,
  input wire logic                       pin_write_ok
);
  import cfg_protect_pkg::*;

  // All properties share the one clock and its reset.
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Read data only appear in the cycle after a read strobe.
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 24'h0)
    else $error("read data seen outside a read answer");
  a_word3_ones: assert property (
    reg_rd && reg_addr == `ADDR_WORD_THREE
    |=> (reg_rdata & `W3_ONES_MASK) == `W3_ONES_MASK)
    else $error("word three unused bits not read as one");
  // Every program request gets exactly one verdict, one cycle later.
  a_nvm_answer: assert property (
    nvm_req.valid |=> nvm_grant != nvm_block)
    else $error("program request without a single verdict");
  a_nvm_quiet: assert property (
    !nvm_req.valid |=> !nvm_grant && !nvm_block)
    else $error("verdict without a program request");
  // Decoded settings never move while the core keeps running.
  a_cfg_hold: assert property (
    run_enable && $past(run_enable)
    |-> $stable(osc_mode) && $stable(usb_reg_en))
    else $error("decoded setting changed while running");
  // Pin-select lock and write permission stay opposite while the core runs.
  a_lock_inverse: assert property (
    run_enable |-> pin_write_ok != pin_select_lock)
    else $error("pin write permission not inverse of lock");
  a_one_way: assert property (
    nv_word_two[`W2_ONE_WAY_BIT] && pin_select_lock |=> pin_select_lock)
    else $error("one-way lock was cleared");
  // No execution while flash is unpowered; power is back on resume.
  a_sleep_dark: assert property (!flash_powered |-> !run_enable)
    else $error("running with flash unpowered");
  a_power_back: assert property ($rose(run_enable) |-> flash_powered)
    else $error("resumed with flash unpowered");
  a_por_halt: assert property (
    $rose(por_event) |-> ##[1:8] !run_enable)
    else $error("power-on event did not stop execution");
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
`include "cfg_protect_params.svh"
// ----------------------------------------------------------------
// Self-checking bench for the configuration protection block
// ----------------------------------------------------------------
module tb;
  import cfg_protect_pkg::*;
  localparam int POWER_UP_DELAY_TIMER = 50;
  localparam int REGULATOR_STARTUP_HOLDOFF = `REGULATOR_STARTUP_HOLDOFF_CYC;
  logic      clk, nrst, core_reg_enable, por_event, brownout_reset;
  logic      sleep_enter, wake_event, nvm_req_cfg, reg_wr, reg_rd;
  logic      usb_reg_en, run_enable, flash_powered, pin_select_lock;
  logic      pin_write_ok, nvm_grant, nvm_block;
  logic [23:0] nv_word_two, nv_word_three, reg_wdata, reg_rdata;
  logic [3:0]  reg_addr;
  nvm_req_t    nvm_req;
  osc_mode_t   osc_mode;
  int          n_mismatch, compares;

  cfg_protect #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER)) u_dut (
    .clk(clk), .nrst(nrst), .nv_word_two(nv_word_two),
    .nv_word_three(nv_word_three), .core_reg_enable(core_reg_enable),
    .por_event(por_event), .brownout_reset(brownout_reset),
    .sleep_enter(sleep_enter), .wake_event(wake_event),
    .nvm_req(nvm_req), .nvm_req_cfg(nvm_req_cfg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .usb_reg_en(usb_reg_en), .osc_mode(osc_mode),
    .run_enable(run_enable), .flash_powered(flash_powered),
    .pin_select_lock(pin_select_lock), .pin_write_ok(pin_write_ok),
    .nvm_grant(nvm_grant), .nvm_block(nvm_block));

  // ----------------------------------------------------------------
  // Compare, bus and sequencing tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [23:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Counts edges until execution is allowed and checks the span.
  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (run_enable !== 1'b1 && n <= hi)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(n >= lo && n <= hi, 1'b1);
  endtask
  task automatic do_reset(input logic [23:0] w2, input logic strap);
    nrst <= 1'b0;
    nv_word_two <= w2;
    nv_word_three <= 24'h00E000;
    core_reg_enable <= strap;
    repeat (16) @(posedge clk);
    chk_bit(flash_powered, 1'b1);
    chk_word({22'h0, osc_mode}, 24'h000003);
    nrst <= 1'b1;
    wait_run(strap ? REGULATOR_STARTUP_HOLDOFF : POWER_UP_DELAY_TIMER, (strap ? REGULATOR_STARTUP_HOLDOFF : POWER_UP_DELAY_TIMER) + 8);
  endtask
  task automatic sleep_cycle(input logic fl, input int lo, input int hi);
    @(posedge clk);
    sleep_enter <= 1'b1;
    repeat (6) @(posedge clk);
    sleep_enter <= 1'b0;
    #1;
    chk_bit(run_enable, 1'b0);
    chk_bit(flash_powered, fl);
    @(posedge clk);
    wake_event <= 1'b1;
    wait_run(lo, hi);
    wake_event <= 1'b0;
  endtask
  task automatic unlock();
    reg_write(`ADDR_PIN_CTRL, 24'h460004);
    reg_write(`ADDR_PIN_CTRL, 24'h570004);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Oscillator and regulator decode, read-back, power events, Sleep.
  task automatic t_decode();
    logic [23:0] w2, d;
    for (int i = 0; i < 4; i++)
    begin
      w2 = {20'h0, i[0], 1'b1, i[1:0]};
      do_reset(w2, 1'b0);
      chk_word({22'h0, osc_mode}, {22'h0, i[1:0]});
      chk_bit(usb_reg_en, ~i[0]);
      reg_read(`ADDR_WORD_THREE, d);
      chk_word(d, 24'h00E000 | `W3_ONES_MASK);
    end
    reg_write(`ADDR_WORD_TWO, 24'h000000);
    reg_read(`ADDR_WORD_TWO, d);
    chk_word(d, w2);
    reg_read(4'hF, d);
    chk_word(d, 24'h000000);
    nv_word_two <= 24'h000004;
    repeat (8) @(posedge clk);
    chk_word({22'h0, osc_mode}, 24'h000003);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0) por_event <= 1'b1;
      else brownout_reset <= 1'b1;
      repeat (8) @(posedge clk);
      por_event <= 1'b0;
      brownout_reset <= 1'b0;
      #1;
      chk_bit(run_enable, 1'b0);
      wait_run(POWER_UP_DELAY_TIMER - 8, POWER_UP_DELAY_TIMER + 8);
    end
    sleep_cycle(1'b0, REGULATOR_STARTUP_HOLDOFF, REGULATOR_STARTUP_HOLDOFF + 12);
    reg_write(`ADDR_STANDBY, 24'h000001);
    sleep_cycle(1'b1, 1, 10);
  endtask
  // Pin-select lock in one-way or free mode.
  task automatic t_pin(input logic ow);
    logic [23:0] d;
    do_reset({19'h0, ow, 4'h4}, 1'b0);
    reg_write(`ADDR_PIN_CTRL, 24'h000002);
    chk_bit(pin_select_lock, 1'b0);
    unlock();
    reg_write(`ADDR_PIN_CTRL, 24'h000002);
    chk_bit(pin_select_lock, 1'b1);
    chk_bit(pin_write_ok, 1'b0);
    reg_read(`ADDR_STATUS, d);
    chk_word(d, 24'h00001B);
    unlock();
    reg_write(`ADDR_PIN_CTRL, 24'h000000);
    reg_read(`ADDR_PIN_CTRL, d);
    chk_bit(d[`PC_LOCK_BIT], ow);
    reg_write(`ADDR_PIN_CTRL, 24'h000002);
    chk_bit(pin_select_lock, ow);
  endtask
  // Regulator hold-off at power-up and on wake with standby off/on.
  task automatic t_holdoff_on();
    do_reset(24'h000004, 1'b1);
    sleep_cycle(1'b0, REGULATOR_STARTUP_HOLDOFF, REGULATOR_STARTUP_HOLDOFF + 12);
    reg_write(`ADDR_STANDBY, 24'h000001);
    sleep_cycle(1'b1, 1, 10);
  endtask
  // Segment, boundary page and last-page protection verdicts.
  task automatic t_protect();
    logic [23:0] w3 [4] = '{24'h00E004, 24'h00C004, 24'h004004, 24'h00A004};
    logic [23:0] a [12] = '{24'h000800, 24'h00FE00, 24'h000000,
      24'h0009FF, 24'h000A00, 24'h000000, 24'h0007FF, 24'h000800,
      24'h00FE00, 24'h00FE00, 24'h00FC00, 24'h000000};
    logic [11:0] ex = 12'b101_110_101_000;
    int k;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(24'h000004, 1'b0);
      nrst <= 1'b0;
      nv_word_three <= w3[i];
      @(posedge clk);
      nrst <= 1'b1;
      wait_run(POWER_UP_DELAY_TIMER, POWER_UP_DELAY_TIMER + 8);
      for (int j = 0; j < 3; j++)
      begin
        k = i * 3 + j;
        @(posedge clk);
        nvm_req <= '{1'b1, k[0], a[k]};
        nvm_req_cfg <= (j == 2) && (i == 0 || i == 3);
        @(posedge clk);
        nvm_req.valid <= 1'b0;
        #1;
        chk_bit(nvm_block, ex[k]);
        chk_bit(nvm_grant, ~ex[k]);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence.
  initial
  begin
    {nrst, core_reg_enable, por_event, brownout_reset} = 4'h0;
    {sleep_enter, wake_event, nvm_req_cfg, reg_wr, reg_rd} = 5'h00;
    {n_mismatch, compares} = 0;
    nv_word_two = `CFG_ERASED;
    nv_word_three = `CFG_ERASED;
    reg_wdata = 24'h000000;
    reg_addr = 4'h0;
    nvm_req = '0;
    t_decode();
    t_pin(1'b1);
    t_pin(1'b0);
    t_holdoff_on();
    t_protect();
    report_and_stop();
  end
  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule

bind cfg_protect cfg_protect_chk u_chk (
  .clk(clk), .nrst(nrst), .nv_word_two(nv_word_two),
  .por_event(por_event), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .nvm_req(nvm_req), .nvm_grant(nvm_grant),
  .nvm_block(nvm_block), .osc_mode(osc_mode), .usb_reg_en(usb_reg_en),
  .run_enable(run_enable), .flash_powered(flash_powered),
  .pin_select_lock(pin_select_lock), .pin_write_ok(pin_write_ok));
